// ---- host_command_model.sv ----
// Host model: frames one command word with its check code per send call.
// Assumes callers enter send just after a rising ref_clk edge.
`timescale 1ns/1ps
`default_nettype none
module host_command_model (
	input wire logic ref_clk,
	output logic cmd_valid,
	output logic [7:0] command_byte_high,
	output logic [7:0] command_byte_low,
	output logic [15:0] packet_check_code
);
	logic [14:0] crc;
	initial begin
		cmd_valid = 1'b0;
		{command_byte_high, command_byte_low, packet_check_code} = 32'h0000_0000;
	end
	task automatic send(input logic [15:0] word, input logic bad);
		crc = monitor_command_pkg::crc_seed_default;
		for (int i = 15; i >= 0; i--) begin
			crc = {crc[13:0], 1'b0} ^ ((word[i] ^ crc[14]) ? monitor_command_pkg::crc_poly_default : 15'h0000);
		end
		{command_byte_high, command_byte_low} = word;
		packet_check_code = {crc ^ {14'h0000, bad}, 1'b0};
		cmd_valid = 1'b1;
		@(posedge ref_clk);
		#1;
	endtask : send
	// Released lines show garbage, so a stale frame can never pass for a new one.
	task automatic idle();
		cmd_valid = 1'b0;
		{command_byte_high, command_byte_low, packet_check_code} = ~{command_byte_high, command_byte_low, packet_check_code};
	endtask : idle
endmodule : host_command_model
`default_nettype wire

// ---- monitor_command_decoder.sv ----
// Command decoder: turns one checked command frame into register-group and conversion actions.
// Assumes cmd_valid pulses once per complete command and check code, in ref_clk.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - high byte upper five bits zero
// - check code covers both command bytes
// - whole chain acts on command together
// - configuration groups A and B access
// - cell groups A to F reads
// - auxiliary groups A to D reads
// - status groups A and B reads
// - pulsing group write, read, clear
// - duty and combined group B access
// - start pulsing, then poll status
// - cell conversion with rate, discharge, group
// - cell open-wire with pull direction
// - cell self-test with pattern, rate
// - overlap measurement of cells seven, thirteen
// - auxiliary conversion, plain or redundant
// - auxiliary open-wire with pull direction
// - auxiliary or status self-test
// - status conversion, plain or redundant
// - combined cell plus auxiliary or sum
// - clear cell, auxiliary, status groups
// - poll only, multiplexer diagnosis
// - master serial group write, read, start
module monitor_command_decoder (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic cmd_valid,
	input wire logic [7:0] command_byte_high,
	input wire logic [7:0] command_byte_low,
	input wire logic [15:0] packet_check_code,
	output logic reg_access,
	output monitor_command_pkg::reg_op_t reg_op,
	output monitor_command_pkg::reg_group_t reg_group,
	output monitor_command_pkg::reg_group_ext_t reg_group_ext,
	output logic conv_start,
	output monitor_command_pkg::conv_kind_t conv_kind,
	output logic [1:0] adc_rate_sel,
	output logic discharge_allow,
	output logic open_wire_pull_dir,
	output logic [1:0] self_test_pattern_sel,
	output logic [2:0] cell_group_sel,
	output logic [2:0] aux_input_sel,
	output logic [2:0] status_item_sel,
	output logic poll_start,
	output logic mux_diagnose_start,
	output logic pulsing_start,
	output logic master_serial_start,
	output logic discharge_muted,
	output logic crc_error,
	output logic command_rejected
);
	crc_link_if link ();

	crc_check crc_check_inst (
		.link(link.checker_end)
	);

	logic [10:0] command_code;
	logic frame_ok;
	logic framing_ok;

	assign link.cmd_word = {command_byte_high, command_byte_low};
	assign link.crc_rx = packet_check_code;
	assign command_code = {command_byte_high[2:0], command_byte_low};

	assign framing_ok = (command_byte_high[7:3] == 5'h00);

	assign frame_ok = cmd_valid && link.crc_ok;

	// Decoded, not yet registered.
	logic dec_reg;
	monitor_command_pkg::reg_op_t dec_op;
	monitor_command_pkg::reg_group_t dec_group;
	monitor_command_pkg::reg_group_ext_t dec_ext;
	logic dec_conv;
	monitor_command_pkg::conv_kind_t dec_kind;
	logic dec_poll;
	logic dec_diag;
	logic dec_pulse;
	logic dec_serial;
	logic dec_mute;
	logic dec_unmute;
	logic dec_known;

	logic [1:0] prefix;
	logic [1:0] variant;
	logic [2:0] low_sel;

	assign prefix = command_code[10:9];
	assign variant = command_code[6:5];
	assign low_sel = command_code[2:0];

	always_comb begin
		dec_reg = 1'b0;
		dec_op = monitor_command_pkg::op_read;
		dec_group = monitor_command_pkg::grp_cfg_a;
		dec_ext = monitor_command_pkg::ext_none;
		dec_conv = 1'b0;
		dec_kind = monitor_command_pkg::conv_none;
		dec_poll = 1'b0;
		dec_diag = 1'b0;
		dec_pulse = 1'b0;
		dec_serial = 1'b0;
		dec_mute = 1'b0;
		dec_unmute = 1'b0;
		unique case (command_code)
			monitor_command_pkg::write_cfg_a_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_write;
			end
			monitor_command_pkg::read_cfg_a_cmd: begin
				dec_reg = 1'b1;
			end
			monitor_command_pkg::write_cfg_b_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_write;
				dec_group = monitor_command_pkg::grp_cfg_b;
			end
			monitor_command_pkg::read_cfg_b_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_cfg_b;
			end
			monitor_command_pkg::read_cell_group_a_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_cell_a;
			end
			monitor_command_pkg::read_cell_group_b_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_cell_b;
			end
			monitor_command_pkg::read_cell_group_c_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_cell_c;
			end
			monitor_command_pkg::read_cell_group_d_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_cell_d;
			end
			monitor_command_pkg::read_cell_group_e_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_cell_e;
			end
			monitor_command_pkg::read_cell_group_f_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_cell_f;
			end
			monitor_command_pkg::read_aux_group_a_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_aux_a;
			end
			monitor_command_pkg::read_aux_group_b_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_aux_b;
			end
			monitor_command_pkg::read_aux_group_c_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_aux_c;
			end
			monitor_command_pkg::read_aux_group_d_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_aux_d;
			end
			monitor_command_pkg::read_stat_group_a_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_stat_a;
			end
			monitor_command_pkg::read_stat_group_b_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_stat_b;
			end
			monitor_command_pkg::write_pulsing_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_write;
				dec_group = monitor_command_pkg::grp_pulsing;
			end
			monitor_command_pkg::read_pulsing_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_pulsing;
			end
			monitor_command_pkg::clear_pulsing_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_clear;
				dec_group = monitor_command_pkg::grp_pulsing;
			end
			monitor_command_pkg::start_pulsing_cmd: begin
				dec_pulse = 1'b1;
				dec_poll = 1'b1;
			end
			monitor_command_pkg::write_duty_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_write;
				dec_group = monitor_command_pkg::grp_duty;
			end
			monitor_command_pkg::read_duty_cmd: begin
				dec_reg = 1'b1;
				dec_group = monitor_command_pkg::grp_duty;
			end
			monitor_command_pkg::write_duty_pulsing_b_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_write;
				dec_ext = monitor_command_pkg::ext_duty_pulsing_b;
			end
			monitor_command_pkg::read_duty_pulsing_b_cmd: begin
				dec_reg = 1'b1;
				dec_ext = monitor_command_pkg::ext_duty_pulsing_b;
			end
			monitor_command_pkg::mute_discharge_cmd: begin
				dec_mute = 1'b1;
			end
			monitor_command_pkg::unmute_discharge_cmd: begin
				dec_unmute = 1'b1;
			end
			// clear all groups of a kind
			monitor_command_pkg::clear_cells_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_clear;
				dec_group = monitor_command_pkg::grp_cell_a;
				dec_ext = monitor_command_pkg::ext_all_of_kind;
			end
			monitor_command_pkg::clear_aux_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_clear;
				dec_group = monitor_command_pkg::grp_aux_a;
				dec_ext = monitor_command_pkg::ext_all_of_kind;
			end
			monitor_command_pkg::clear_stat_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_clear;
				dec_group = monitor_command_pkg::grp_stat_a;
				dec_ext = monitor_command_pkg::ext_all_of_kind;
			end
			monitor_command_pkg::poll_conversion_cmd: begin
				dec_poll = 1'b1;
			end
			monitor_command_pkg::mux_diagnose_cmd: begin
				dec_diag = 1'b1;
				dec_poll = 1'b1;
			end
			monitor_command_pkg::write_master_serial_cmd: begin
				dec_reg = 1'b1;
				dec_op = monitor_command_pkg::op_write;
				dec_ext = monitor_command_pkg::ext_master_serial;
			end
			monitor_command_pkg::read_master_serial_cmd: begin
				dec_reg = 1'b1;
				dec_ext = monitor_command_pkg::ext_master_serial;
			end
			monitor_command_pkg::start_master_serial_cmd: begin
				dec_serial = 1'b1;
			end
			default: begin
				// Self-test patterns 01 and 10 win over a conversion whose selector reads all ones.
				if (prefix == monitor_command_pkg::cell_prefix) begin
					if (command_code[4:3] == 2'h0 && low_sel == monitor_command_pkg::all_ones_sel &&
							(variant == monitor_command_pkg::self_test_one ||
							variant == monitor_command_pkg::self_test_two)) begin
						dec_kind = monitor_command_pkg::conv_cell_selftest;
					end else if (command_code[5] && command_code[3]) begin
						dec_kind = monitor_command_pkg::conv_cell_open_wire;
					end else if (variant == monitor_command_pkg::plain_variant && !command_code[3]) begin
						dec_kind = monitor_command_pkg::conv_cell;
					end else if (variant == monitor_command_pkg::redundant_variant && !command_code[3] &&
							low_sel == monitor_command_pkg::overlap_sel) begin
						dec_kind = monitor_command_pkg::conv_overlap;
					end
				end else if (prefix == monitor_command_pkg::aux_prefix) begin
					if (variant == monitor_command_pkg::plain_variant &&
							low_sel == monitor_command_pkg::all_ones_sel) begin
						dec_kind = command_code[3] ? monitor_command_pkg::conv_cell_plus_aux :
							monitor_command_pkg::conv_cell_plus_sum;
					end else if (command_code[4:3] == 2'h0 && low_sel == monitor_command_pkg::all_ones_sel &&
							(variant == monitor_command_pkg::self_test_one ||
							variant == monitor_command_pkg::self_test_two)) begin
						dec_kind = monitor_command_pkg::conv_aux_selftest;
					end else if (command_code[4:3] == 2'h1 && low_sel == monitor_command_pkg::all_ones_sel &&
							(variant == monitor_command_pkg::self_test_one ||
							variant == monitor_command_pkg::self_test_two)) begin
						dec_kind = monitor_command_pkg::conv_stat_selftest;
					end else if (!command_code[5] && command_code[4] && !command_code[3]) begin
						dec_kind = monitor_command_pkg::conv_aux_open_wire;
					end else if (command_code[4:3] == 2'h0 && variant == monitor_command_pkg::plain_variant) begin
						dec_kind = monitor_command_pkg::conv_aux;
					end else if (command_code[4:3] == 2'h0 && variant == monitor_command_pkg::redundant_variant) begin
						dec_kind = monitor_command_pkg::conv_aux_redundant;
					end else if (command_code[4:3] == 2'h1 && variant == monitor_command_pkg::plain_variant) begin
						dec_kind = monitor_command_pkg::conv_stat;
					end else if (command_code[4:3] == 2'h1 && variant == monitor_command_pkg::redundant_variant) begin
						dec_kind = monitor_command_pkg::conv_stat_redundant;
					end
				end
				dec_conv = (dec_kind != monitor_command_pkg::conv_none);
				dec_poll = dec_conv;
			end
		endcase
	end

	assign dec_known = dec_reg || dec_conv || dec_poll || dec_diag || dec_pulse || dec_serial ||
		dec_mute || dec_unmute;

	logic accept;
	assign accept = frame_ok && framing_ok && dec_known;

	logic next_reg_access;
	monitor_command_pkg::reg_op_t next_reg_op;
	monitor_command_pkg::reg_group_t next_reg_group;
	monitor_command_pkg::reg_group_ext_t next_reg_group_ext;
	logic next_conv_start;
	monitor_command_pkg::conv_kind_t next_conv_kind;
	logic [1:0] next_adc_rate_sel;
	logic next_discharge_allow;
	logic next_open_wire_pull_dir;
	logic [1:0] next_self_test_pattern_sel;
	logic [2:0] next_cell_group_sel;
	logic [2:0] next_aux_input_sel;
	logic [2:0] next_status_item_sel;
	logic next_discharge_muted;

	always_comb begin
		next_reg_access = accept && dec_reg;
		next_reg_op = reg_op;
		next_reg_group = reg_group;
		next_reg_group_ext = reg_group_ext;
		next_conv_start = accept && dec_conv;
		next_conv_kind = conv_kind;
		next_adc_rate_sel = adc_rate_sel;
		next_discharge_allow = discharge_allow;
		next_open_wire_pull_dir = open_wire_pull_dir;
		next_self_test_pattern_sel = self_test_pattern_sel;
		next_cell_group_sel = cell_group_sel;
		next_aux_input_sel = aux_input_sel;
		next_status_item_sel = status_item_sel;
		next_discharge_muted = discharge_muted;
		if (accept && dec_reg) begin
			next_reg_op = dec_op;
			next_reg_group = dec_group;
			next_reg_group_ext = dec_ext;
		end
		if (accept && dec_conv) begin
			// Option fields are held until the next conversion so the converter may sample late.
			next_conv_kind = dec_kind;
			next_adc_rate_sel = command_code[8:7];
			next_discharge_allow = command_code[4];
			next_open_wire_pull_dir = command_code[6];
			next_self_test_pattern_sel = command_code[6:5];
			if (dec_kind inside {monitor_command_pkg::conv_cell, monitor_command_pkg::conv_cell_open_wire}) begin
				next_cell_group_sel = low_sel;
			end
			if (dec_kind inside {monitor_command_pkg::conv_aux, monitor_command_pkg::conv_aux_redundant,
					monitor_command_pkg::conv_aux_open_wire}) begin
				next_aux_input_sel = low_sel;
			end
			if (dec_kind inside {monitor_command_pkg::conv_stat, monitor_command_pkg::conv_stat_redundant}) begin
				next_status_item_sel = low_sel;
			end
		end
		if (accept && dec_mute) begin
			next_discharge_muted = 1'b1;
		end else if (accept && dec_unmute) begin
			next_discharge_muted = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_access <= 1'b0;
			reg_op <= monitor_command_pkg::op_read;
			reg_group <= monitor_command_pkg::grp_cfg_a;
			reg_group_ext <= monitor_command_pkg::ext_none;
			conv_start <= 1'b0;
			conv_kind <= monitor_command_pkg::conv_none;
			adc_rate_sel <= monitor_command_pkg::rate_reset;
			discharge_allow <= 1'b0;
			open_wire_pull_dir <= 1'b0;
			self_test_pattern_sel <= monitor_command_pkg::rate_reset;
			cell_group_sel <= monitor_command_pkg::sel_reset;
			aux_input_sel <= monitor_command_pkg::sel_reset;
			status_item_sel <= monitor_command_pkg::sel_reset;
			poll_start <= 1'b0;
			mux_diagnose_start <= 1'b0;
			pulsing_start <= 1'b0;
			master_serial_start <= 1'b0;
			discharge_muted <= 1'b0;
			crc_error <= 1'b0;
			command_rejected <= 1'b0;
		end else begin
			reg_access <= next_reg_access;
			reg_op <= next_reg_op;
			reg_group <= next_reg_group;
			reg_group_ext <= next_reg_group_ext;
			conv_start <= next_conv_start;
			conv_kind <= next_conv_kind;
			adc_rate_sel <= next_adc_rate_sel;
			discharge_allow <= next_discharge_allow;
			open_wire_pull_dir <= next_open_wire_pull_dir;
			self_test_pattern_sel <= next_self_test_pattern_sel;
			cell_group_sel <= next_cell_group_sel;
			aux_input_sel <= next_aux_input_sel;
			status_item_sel <= next_status_item_sel;
			poll_start <= accept && dec_poll;
			mux_diagnose_start <= accept && dec_diag;
			pulsing_start <= accept && dec_pulse;
			master_serial_start <= accept && dec_serial;
			discharge_muted <= next_discharge_muted;
			crc_error <= cmd_valid && !link.crc_ok;
			command_rejected <= frame_ok && !(framing_ok && dec_known);
		end
	end
endmodule : monitor_command_decoder
`default_nettype wire

// ---- monitor_command_decoder_bench.sv ----
// Self-checking bench for the command decoder, fed by the host model.
// Assumes a 100 MHz ref_clk and a one-cycle answer latency.
`timescale 1ns/1ps
`default_nettype none
module monitor_command_decoder_bench;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic cmd_valid, reg_access, conv_start, poll_start, mux_diagnose_start, pulsing_start, master_serial_start;
	logic discharge_muted, crc_error, command_rejected, discharge_allow, open_wire_pull_dir;
	logic [7:0] command_byte_high, command_byte_low;
	logic [15:0] packet_check_code;
	logic [1:0] adc_rate_sel, self_test_pattern_sel;
	logic [2:0] cell_group_sel, aux_input_sel, status_item_sel, sel;
	monitor_command_pkg::reg_op_t reg_op;
	monitor_command_pkg::reg_group_t reg_group;
	monitor_command_pkg::reg_group_ext_t reg_group_ext;
	monitor_command_pkg::conv_kind_t conv_kind;
	int bad_count = 0;
	int num_checks = 0;
	logic [23:0] fixed_tbl [28] = '{24'h00_1000, 24'h00_2040, 24'h02_4001, 24'h02_6041, 24'h00_4042, 24'h00_6043,
		24'h00_8044, 24'h00_A045, 24'h00_9046, 24'h00_B047, 24'h00_C048, 24'h00_E049, 24'h00_D04A, 24'h00_F04B,
		24'h01_004C, 24'h01_204D, 24'h01_400E, 24'h01_604E, 24'h01_808E, 24'h02_000F, 24'h02_204F, 24'h01_C010,
		24'h01_E050, 24'h71_10B2, 24'h71_20B8, 24'h71_30BC, 24'h72_1020, 24'h72_2060};
	logic [15:0] conv_tbl [13] = '{16'h3731, 16'h2EA2, 16'h2273, 16'h3914, 16'h4655, 16'h4026, 16'h4537,
		16'h4478, 16'h4699, 16'h40AA, 16'h42FB, 16'h47FC, 16'h477D};
	logic [19:0] misc_tbl [6] = '{20'h7_1440, 20'h7_1560, 20'h0_1950, 20'h7_2308, 20'h0_2801, 20'h0_2900};
	monitor_command_decoder monitor_command_decoder_inst (.*);
	host_command_model host_command_model_inst (.*);
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		if (bad_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic cmd(input logic [10:0] c);
		host_command_model_inst.send({5'h00, c}, 1'b0);
	endtask : cmd
	task automatic t_fixed();
		foreach (fixed_tbl[i]) begin
			cmd(fixed_tbl[i][22:12]);
			sel = 3'h0;
			chk("group", {8'h01, fixed_tbl[i][7:0]}, {7'h00, reg_access, reg_op, reg_group_ext,
				(fixed_tbl[i][5] ^ fixed_tbl[i][4]) ? fixed_tbl[i][3:0] : reg_group});
		end
	endtask : t_fixed
	task automatic t_conv();
		logic [10:0] c;
		logic [3:0] k;
		foreach (conv_tbl[i]) begin
			c = conv_tbl[i][14:4];
			k = conv_tbl[i][3:0];
			cmd(c);
			sel = (k inside {4'h1, 4'h2}) ? cell_group_sel : (k inside {4'h5, 4'h6, 4'h7}) ? aux_input_sel :
				(k inside {4'h9, 4'hA}) ? status_item_sel : c[2:0];
			chk("conv", {3'h3, k, c[8:7], c[4], c[6:5], c[6], c[2:0]}, {1'b0, conv_start, poll_start, conv_kind,
				adc_rate_sel, discharge_allow, self_test_pattern_sel, open_wire_pull_dir, sel});
		end
	endtask : t_conv
	task automatic t_misc();
		logic allow;
		allow = discharge_allow;
		foreach (misc_tbl[i]) begin
			cmd(misc_tbl[i][18:8]);
			chk("misc", misc_tbl[i][6:0], {poll_start, mux_diagnose_start, pulsing_start,
				master_serial_start, conv_start, reg_access, discharge_muted});
		end
		chk("allow", allow, discharge_allow);
	endtask : t_misc
	task automatic t_refuse(input logic [15:0] word, input logic bad);
		logic [3:0] kind;
		kind = conv_kind;
		host_command_model_inst.send(word, bad);
		chk("refuse", {bad, !bad, 4'h0, kind}, {crc_error, command_rejected, conv_start, reg_access,
			poll_start, discharge_muted, conv_kind});
	endtask : t_refuse
	initial begin
		repeat (12) @(posedge ref_clk);
		#1 srst = 1'b0;
		chk("reset", 16'h0020, {reg_op, conv_kind, discharge_muted});
		t_fixed();
		t_conv();
		t_misc();
		t_refuse(16'h0373, 1'b1);
		t_refuse(16'h0B73, 1'b0);
		t_refuse(16'h07FF, 1'b0);
		t_refuse(16'h0028, 1'b1);
		host_command_model_inst.idle();
		give_verdict();
	end
endmodule : monitor_command_decoder_bench
`default_nettype wire

// ---- monitor_command_decoder_properties.sv ----
// Assertions on the decoder's answer pulses and its discharge_muted flag.
// Bound to the decoder top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module monitor_command_decoder_properties (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic cmd_valid,
	input wire logic [7:0] command_byte_high,
	input wire logic [7:0] command_byte_low,
	input wire logic reg_access,
	input wire logic poll_start,
	input wire logic mux_diagnose_start,
	input wire logic discharge_muted,
	input wire logic crc_error,
	input wire logic command_rejected
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	sequence s_cmd(logic [10:0] c);
		cmd_valid && command_byte_high == {5'h00, c[10:8]} && command_byte_low == c[7:0];
	endsequence
	AST_IDLE: assert property (!cmd_valid |=> !(reg_access || poll_start || crc_error || command_rejected))
		else $error("pulse without command");
	AST_ONE: assert property (cmd_valid |=> $onehot0({reg_access, poll_start, crc_error, command_rejected}))
		else $error("more than one answer");
	AST_UPPER: assert property (cmd_valid && command_byte_high[7:3] != 5'h00 |=> crc_error || command_rejected)
		else $error("upper bits accepted");
	AST_CELL: assert property (s_cmd(11'h373) |=> poll_start || crc_error) else $error("cell convert lost");
	AST_READ: assert property (s_cmd(11'h002) |=> reg_access || crc_error) else $error("read lost");
	AST_DIAG: assert property (s_cmd(11'h715) |=> mux_diagnose_start && poll_start || crc_error)
		else $error("diagnose lost");
	AST_MUTE: assert property (s_cmd(11'h028) |=> discharge_muted || crc_error) else $error("mute lost");
	AST_UNMUTE: assert property (s_cmd(11'h029) |=> !discharge_muted || crc_error) else $error("unmute lost");
	AST_KEEP: assert property (crc_error || command_rejected |-> $stable(discharge_muted))
		else $error("refused command changed mute");
endmodule : monitor_command_decoder_properties
bind monitor_command_decoder monitor_command_decoder_properties monitor_command_decoder_properties_inst (.*);
`default_nettype wire

// ---- monitor_command_pkg.sv ----
// Constants and types shared by the command decoder and its check-code helper.
// Assumes the serial front end delivers whole command frames; no framing lives here.
`default_nettype none
package monitor_command_pkg;

	// Fixed command codes, 11 bits each.
	localparam logic [10:0] write_cfg_a_cmd = 11'h001;
	localparam logic [10:0] read_cfg_a_cmd = 11'h002;
	localparam logic [10:0] write_cfg_b_cmd = 11'h024;
	localparam logic [10:0] read_cfg_b_cmd = 11'h026;
	localparam logic [10:0] read_cell_group_a_cmd = 11'h004;
	localparam logic [10:0] read_cell_group_b_cmd = 11'h006;
	localparam logic [10:0] read_cell_group_c_cmd = 11'h008;
	localparam logic [10:0] read_cell_group_d_cmd = 11'h00A;
	localparam logic [10:0] read_cell_group_e_cmd = 11'h009;
	localparam logic [10:0] read_cell_group_f_cmd = 11'h00B;
	localparam logic [10:0] read_aux_group_a_cmd = 11'h00C;
	localparam logic [10:0] read_aux_group_b_cmd = 11'h00E;
	localparam logic [10:0] read_aux_group_c_cmd = 11'h00D;
	localparam logic [10:0] read_aux_group_d_cmd = 11'h00F;
	localparam logic [10:0] read_stat_group_a_cmd = 11'h010;
	localparam logic [10:0] read_stat_group_b_cmd = 11'h012;
	localparam logic [10:0] write_pulsing_cmd = 11'h014;
	localparam logic [10:0] read_pulsing_cmd = 11'h016;
	localparam logic [10:0] clear_pulsing_cmd = 11'h018;
	localparam logic [10:0] start_pulsing_cmd = 11'h019;
	localparam logic [10:0] write_duty_cmd = 11'h020;
	localparam logic [10:0] read_duty_cmd = 11'h022;
	localparam logic [10:0] write_duty_pulsing_b_cmd = 11'h01C;
	localparam logic [10:0] read_duty_pulsing_b_cmd = 11'h01E;
	localparam logic [10:0] mute_discharge_cmd = 11'h028;
	localparam logic [10:0] unmute_discharge_cmd = 11'h029;
	localparam logic [10:0] clear_cells_cmd = 11'h711;
	localparam logic [10:0] clear_aux_cmd = 11'h712;
	localparam logic [10:0] clear_stat_cmd = 11'h713;
	localparam logic [10:0] poll_conversion_cmd = 11'h714;
	localparam logic [10:0] mux_diagnose_cmd = 11'h715;
	localparam logic [10:0] write_master_serial_cmd = 11'h721;
	localparam logic [10:0] read_master_serial_cmd = 11'h722;
	localparam logic [10:0] start_master_serial_cmd = 11'h723;

	// Prefix in bits 10:9 of the pattern commands.
	localparam logic [1:0] cell_prefix = 2'h1;
	localparam logic [1:0] aux_prefix = 2'h2;
	localparam logic [2:0] all_ones_sel = 3'h7;
	localparam logic [2:0] overlap_sel = 3'h1;
	localparam logic [1:0] plain_variant = 2'h3;
	localparam logic [1:0] redundant_variant = 2'h0;
	localparam logic [1:0] self_test_one = 2'h1;
	localparam logic [1:0] self_test_two = 2'h2;

	// Check-code defaults; the width of the code is 15 bits, sent shifted left by one.
	localparam logic [14:0] crc_poly_default = 15'h4599;
	localparam logic [14:0] crc_seed_default = 15'h0010;

	// Reset values of the held outputs.
	localparam logic [1:0] rate_reset = 2'h0;
	localparam logic [2:0] sel_reset = 3'h0;

	typedef enum logic [1:0] {
		op_write = 2'b00,
		op_read = 2'b01,
		op_clear = 2'b10
	} reg_op_t;

	typedef enum logic [3:0] {
		grp_cfg_a = 4'b0000,
		grp_cfg_b = 4'b0001,
		grp_cell_a = 4'b0010,
		grp_cell_b = 4'b0011,
		grp_cell_c = 4'b0100,
		grp_cell_d = 4'b0101,
		grp_cell_e = 4'b0110,
		grp_cell_f = 4'b0111,
		grp_aux_a = 4'b1000,
		grp_aux_b = 4'b1001,
		grp_aux_c = 4'b1010,
		grp_aux_d = 4'b1011,
		grp_stat_a = 4'b1100,
		grp_stat_b = 4'b1101,
		grp_pulsing = 4'b1110,
		grp_duty = 4'b1111
	} reg_group_t;

	// Groups that do not fit the sixteen above travel with reg_group_ext set.
	typedef enum logic [1:0] {
		ext_none = 2'b00,
		ext_duty_pulsing_b = 2'b01,
		ext_master_serial = 2'b10,
		ext_all_of_kind = 2'b11
	} reg_group_ext_t;

	typedef enum logic [3:0] {
		conv_none = 4'b0000,
		conv_cell = 4'b0001,
		conv_cell_open_wire = 4'b0010,
		conv_cell_selftest = 4'b0011,
		conv_overlap = 4'b0100,
		conv_aux = 4'b0101,
		conv_aux_redundant = 4'b0110,
		conv_aux_open_wire = 4'b0111,
		conv_aux_selftest = 4'b1000,
		conv_stat = 4'b1001,
		conv_stat_redundant = 4'b1010,
		conv_stat_selftest = 4'b1011,
		conv_cell_plus_aux = 4'b1100,
		conv_cell_plus_sum = 4'b1101
	} conv_kind_t;

endpackage : monitor_command_pkg
`default_nettype wire

// ---- pec_check.sv ----
// Check-code helper: recomputes the 15-bit code over a 16-bit command word.
// Assumes the received code arrives left-aligned with its low bit zero.
`timescale 1ns/1ps
`default_nettype none
module crc_check #(
	parameter logic [14:0] poly = monitor_command_pkg::crc_poly_default,
	parameter logic [14:0] seed = monitor_command_pkg::crc_seed_default
) (
	crc_link_if.checker_end link
);
	logic [14:0] crc;

	always_comb begin
		crc = seed;
		for (int i = 15; i >= 0; i--) begin
			if (link.cmd_word[i] ^ crc[14]) begin
				crc = {crc[13:0], 1'b0} ^ poly;
			end else begin
				crc = {crc[13:0], 1'b0};
			end
		end
	end

	// The unused low bit is also required to be zero, so a shifted code is caught.
	assign link.crc_ok = (link.crc_rx == {crc, 1'b0});
endmodule : crc_check
`default_nettype wire

// ---- pec_link_if.sv ----
// Carrier between the decoder and its check-code helper.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
`default_nettype none
interface crc_link_if;
	logic [15:0] cmd_word;
	logic [15:0] crc_rx;
	logic crc_ok;
	modport checker_end (input cmd_word, input crc_rx, output crc_ok);
	modport user_end (output cmd_word, output crc_rx, input crc_ok);
endinterface : crc_link_if
`default_nettype wire
